// ==== pkg/fa_pkg.sv ====
// shared constants and helpers for the address-mode and soft-reset command link
package fa_pkg;
    // instruction codes
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_RDPAR = 8'h5A;
    localparam logic [7:0] OP_RSTEN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    localparam logic [7:0] OP_EN4B = 8'hB7;
    localparam logic [7:0] OP_IDLE = 8'hFF;
    // link widths in wires
    localparam logic [2:0] WID_1 = 3'h1;
    localparam logic [2:0] WID_2 = 3'h2;
    localparam logic [2:0] WID_4 = 3'h4;
    // frame bit positions
    localparam logic [5:0] OPC_BITS = 6'h08;
    localparam logic [5:0] WDATA_END = 6'h10;
    localparam logic [5:0] ADDR_END = 6'h20;
    localparam logic [5:0] EXIT_BITS = 6'h20;
    localparam logic [5:0] BIT_SAT = 6'h38;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // parameter area: fixed doubleword at 3Ch..3Fh
    localparam logic [7:0] PAR_OFS0 = 8'h3C;
    localparam logic [7:0] PAR_OFS1 = 8'h3D;
    localparam logic [7:0] PAR_OFS2 = 8'h3E;
    localparam logic [7:0] PAR_OFS3 = 8'h3F;
    localparam logic [7:0] PAR_BYTE0 = 8'hF0;
    localparam logic [7:0] PAR_BYTE1 = 8'h30;
    localparam logic [7:0] PAR_BYTE2 = 8'hF8;
    localparam logic [7:0] PAR_BYTE3 = 8'hA1;
    localparam logic [7:0] PAR_BLANK = 8'hFF;
    // status register 1
    localparam logic [7:0] SR1_RESET = 8'h00;
    localparam logic [7:0] SR1_WEL_MASK = 8'h02;
    localparam logic [7:0] SR1_VOL_MASK = 8'h03;
    localparam int SR1_WEL = 1;
    // host serial clock timing: 25 MHz ref, 80 ns half period
    localparam int REF_MHZ = 25;
    localparam int SCK_HALF_NS = 80;
    localparam logic [3:0] PH_HIGH = 4'((SCK_HALF_NS * REF_MHZ) / 1000);
    localparam logic [3:0] PH_LAST = 4'((2 * SCK_HALF_NS * REF_MHZ) / 1000 - 1);
    localparam logic [3:0] GAP_LAST = 4'h7;

    // shift w new bits into the low end
    function automatic logic [31:0] fa_shift(input logic [31:0] sh, input logic [3:0] d,
                                             input logic [2:0] w);
        if (w == WID_4)
            return {sh[27:0], d};
        else if (w == WID_2)
            return {sh[29:0], d[1:0]};
        else
            return {sh[30:0], d[0]};
    endfunction

    // place the top w bits of a byte on the pins; single wire uses pin 1 for the device
    function automatic logic [3:0] fa_put(input logic [7:0] b, input logic [2:0] w,
                                          input logic dev_side);
        if (w == WID_4)
            return b[7:4];
        else if (w == WID_2)
            return {2'h0, b[7:6]};
        else if (dev_side)
            return {2'h0, b[7], 1'h0};
        else
            return {3'h0, b[7]};
    endfunction

    // parameter area lookup
    function automatic logic [7:0] fa_par_byte(input logic [7:0] ofs);
        unique case (ofs)
            PAR_OFS0: return PAR_BYTE0;
            PAR_OFS1: return PAR_BYTE1;
            PAR_OFS2: return PAR_BYTE2;
            PAR_OFS3: return PAR_BYTE3;
            default: return PAR_BLANK;
        endcase
    endfunction
endpackage

// ==== pkg/fa_link_if.sv ====
// serial command link between host controller and device
interface fa_link_if;
    logic cs_n;
    logic sck;
    logic [3:0] host_dq_o;
    logic [3:0] host_dq_oe;
    logic [3:0] dev_dq_o;
    logic [3:0] dev_dq_oe;
    logic [3:0] dq;

    // wire level: host, else device, else pulled high
    assign dq = (host_dq_oe & host_dq_o) | (~host_dq_oe & dev_dq_oe & dev_dq_o)
              | (~host_dq_oe & ~dev_dq_oe);

    modport dev(input cs_n, input sck, input dq, output dev_dq_o, output dev_dq_oe);
    modport host(output cs_n, output sck, output host_dq_o, output host_dq_oe, input dq);
endinterface

// ==== verilog/fa_dev.sv ====
// device end: command decode for address mode, soft reset, status write enable
module fa_dev import fa_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // link
    fa_link_if.dev link,
    // configuration
    input wire logic [2:0] link_width,
    // state
    output logic addr4,
    output logic [7:0] sr1,
    output logic rst_armed,
    // events
    output logic soft_rst,
    output logic wr_rejected,
    output logic cmd_done,
    output logic [7:0] cmd_code
);
    logic cs_q;
    logic sck_q;
    logic [5:0] bitcnt;
    logic [7:0] opcode;
    logic [31:0] sh;
    logic [7:0] par_addr;
    logic [7:0] obuf;
    logic [3:0] ocnt;
    logic rise;
    logic fall;
    logic frame_end;
    logic out_phase;
    logic exec;
    logic exact_op;
    logic do_rst;
    logic [31:0] next_sh;
    logic [5:0] next_bitcnt;
    logic [7:0] par_b;
    logic wr_frame;

    // a one-byte command of the given code, closed after exactly eight bits
    function automatic logic one_byte_cmd(input logic exact, input logic [7:0] op,
                                          input logic [7:0] code);
        return exact && (op == code);
    endfunction

    // edge and frame decode
    always_comb begin
        rise = ~link.cs_n & link.sck & ~sck_q;
        fall = ~link.cs_n & ~link.sck & sck_q;
        frame_end = link.cs_n & ~cs_q;
        next_sh = fa_shift(sh, link.dq, link_width);
        next_bitcnt = bitcnt + {3'h0, link_width};
        out_phase = (opcode == OP_RDPAR) && (bitcnt >= ADDR_END);
        // commands act only once the host raises chip select
        exec = frame_end && (bitcnt >= OPC_BITS);
        exact_op = exec && (bitcnt == OPC_BITS);
        // reset acts only from the armed state; a longer frame never counts
        do_rst = one_byte_cmd(exact_op, opcode, OP_RST) && rst_armed;
        wr_frame = exec && (opcode == OP_WRSR) && (bitcnt == WDATA_END);
        par_b = fa_par_byte(par_addr);
    end

    // pin history
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cs_q <= 1'b1;
            sck_q <= 1'b0;
        end else begin
            cs_q <= link.cs_n;
            sck_q <= link.sck;
        end
    end

    // bit counter, cleared between frames
    // saturates so a long read cannot wrap back into the opcode slot
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bitcnt <= '0;
        end else if (link.cs_n) begin
            bitcnt <= '0;
        end else if (rise && bitcnt < BIT_SAT) begin
            bitcnt <= next_bitcnt;
        end
    end

    // input shift register and opcode capture
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sh <= '0;
            opcode <= OP_IDLE;
        end else begin
            if (rise)
                sh <= next_sh;
            if (frame_end)
                opcode <= OP_IDLE;
            else if (rise && next_bitcnt == OPC_BITS)
                opcode <= next_sh[7:0];
        end
    end

    // parameter address: low byte of the address, advances per byte sent
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            par_addr <= '0;
        end else if (rise && opcode == OP_RDPAR && next_bitcnt == ADDR_END) begin
            par_addr <= next_sh[7:0];
        end else if (fall && out_phase && ocnt == 4'h0) begin
            par_addr <= par_addr + 8'h01;
        end
    end

    // parameter data out, changed on falling serial clock
    // single wire: device drives dq1 alone, the host owns dq0
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            obuf <= '0;
            ocnt <= '0;
            link.dev_dq_o <= '0;
            link.dev_dq_oe <= '0;
        end else if (link.cs_n) begin
            ocnt <= '0;
            link.dev_dq_oe <= '0;
        end else if (fall && out_phase) begin
            link.dev_dq_oe <= fa_put(PAR_BLANK, link_width, 1'b1);
            if (ocnt == 4'h0) begin
                link.dev_dq_o <= fa_put(par_b, link_width, 1'b1);
                obuf <= 8'(par_b << link_width);
                ocnt <= BYTE_BITS - {1'b0, link_width};
            end else begin
                link.dev_dq_o <= fa_put(obuf, link_width, 1'b1);
                obuf <= 8'(obuf << link_width);
                ocnt <= ocnt - {1'b0, link_width};
            end
        end
    end

    // address width mode
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            addr4 <= 1'b0;
        end else if (do_rst) begin
            addr4 <= 1'b0;
        end else if (one_byte_cmd(exact_op, opcode, OP_EN4B)) begin
            addr4 <= 1'b1;
        end
    end

    // reset enable latch: only the very next command may use it
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_armed <= 1'b0;
        end else if (exec) begin
            rst_armed <= one_byte_cmd(exact_op, opcode, OP_RSTEN);
        end
    end

    // status register 1 with write enable latch
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sr1 <= SR1_RESET;
        end else if (do_rst) begin
            sr1 <= sr1 & ~SR1_VOL_MASK;
        end else if (one_byte_cmd(exact_op, opcode, OP_WREN)) begin
            sr1 <= sr1 | SR1_WEL_MASK;
        end else if (wr_frame && sr1[SR1_WEL]) begin
            sr1 <= sh[7:0] & ~SR1_VOL_MASK;
        end
    end

    // refused status write: no write enable latched
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_rejected <= 1'b0;
        end else begin
            wr_rejected <= wr_frame && !sr1[SR1_WEL];
        end
    end

    // soft reset completion pulse
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= do_rst;
        end
    end

    // completion events
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cmd_done <= 1'b0;
            cmd_code <= OP_IDLE;
        end else begin
            cmd_done <= exec;
            if (exec)
                cmd_code <= opcode;
        end
    end
endmodule

// ==== verilog/fa_host.sv ====
// host end: serial command master issuing one frame per request
module fa_host import fa_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // link
    fa_link_if.host link,
    // configuration
    input wire logic [2:0] link_width,
    // request
    input wire logic req_valid,
    input wire logic req_exit,
    input wire logic [7:0] req_op,
    input wire logic [23:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic [2:0] req_rd_len,
    output logic req_ready,
    // response
    output logic rsp_valid,
    output logic [31:0] rsp_data
);
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_GAP} fa_hstate_t;

    fa_hstate_t state;
    logic [3:0] ph;
    logic [2:0] w;
    logic [39:0] tx;
    logic [5:0] tx_left;
    logic [5:0] rx_left;
    logic [31:0] rx;
    logic grp_rx;
    logic take;
    logic grp_start;
    logic frame_over;
    logic [3:0] sample;

    // sequencing decode
    always_comb begin
        take = (state == ST_IDLE) && req_valid && req_ready;
        grp_start = (state == ST_RUN) && (ph == 4'h0);
        frame_over = grp_start && (tx_left == 6'h0) && (rx_left == 6'h0);
        sample = (w == WID_1) ? {3'h0, link.dq[1]} : link.dq;
    end

    // frame state and phase counter
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            ph <= '0;
            req_ready <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    req_ready <= 1'b1;
                    ph <= '0;
                    if (take) begin
                        req_ready <= 1'b0;
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    ph <= (ph == PH_LAST) ? 4'h0 : ph + 4'h1;
                    if (frame_over) begin
                        ph <= '0;
                        state <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    ph <= ph + 4'h1;
                    if (ph == GAP_LAST)
                        state <= ST_IDLE;
                end
            endcase
        end
    end

    // transmit content; mode exit is eight quad clocks of all ones
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx <= '0;
            tx_left <= '0;
            rx_left <= '0;
            w <= WID_1;
        end else if (take) begin
            if (req_exit) begin
                tx <= '1;
                tx_left <= EXIT_BITS;
                rx_left <= '0;
                w <= WID_4;
            end else begin
                w <= link_width;
                rx_left <= {req_rd_len, 3'h0};
                if (req_op == OP_RDPAR) begin
                    tx <= {req_op, req_addr, 8'h00};
                    tx_left <= ADDR_END;
                end else if (req_op == OP_WRSR) begin
                    tx <= {req_op, req_wdata, 24'h000000};
                    tx_left <= WDATA_END;
                end else begin
                    tx <= {req_op, 32'h00000000};
                    tx_left <= OPC_BITS;
                end
            end
        end else if (grp_start && tx_left != 6'h0) begin
            tx <= 40'(tx << w);
            tx_left <= tx_left - {3'h0, w};
        end else if (state == ST_RUN && ph == PH_HIGH && grp_rx) begin
            rx_left <= rx_left - {3'h0, w};
        end
    end

    // link pins: data changes while clock low, sampled as clock rises
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            link.cs_n <= 1'b1;
            link.sck <= 1'b0;
            link.host_dq_o <= '0;
            link.host_dq_oe <= '0;
            grp_rx <= 1'b0;
        end else if (take) begin
            link.cs_n <= 1'b0;
        end else if (frame_over) begin
            link.cs_n <= 1'b1;
            link.sck <= 1'b0; // idle low between frames
            link.host_dq_oe <= '0;
            grp_rx <= 1'b0;
        end else if (grp_start) begin
            link.sck <= 1'b0;
            if (tx_left != 6'h0) begin
                link.host_dq_o <= fa_put(tx[39:32], w, 1'b0);
                link.host_dq_oe <= fa_put(PAR_BLANK, w, 1'b0);
                grp_rx <= 1'b0;
            end else begin
                link.host_dq_oe <= '0;
                grp_rx <= 1'b1;
            end
        end else if (state == ST_RUN && ph == PH_HIGH) begin
            link.sck <= 1'b1;
        end
    end

    // receive data and response
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx <= '0;
            rsp_data <= '0;
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= frame_over && (rx != 32'h0 || grp_rx);
            if (take)
                rx <= '0;
            else if (state == ST_RUN && ph == PH_HIGH && grp_rx)
                rx <= fa_shift(rx, sample, w);
            if (frame_over)
                rsp_data <= rx;
        end
    end
endmodule

// ==== test/fa_asserts.sv ====
// concurrent checks on the command link and the device state
module fa_asserts import fa_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // link
    input wire logic cs_n,
    input wire logic [3:0] dev_dq_oe,
    // device state and events
    input wire logic addr4,
    input wire logic [7:0] sr1,
    input wire logic rst_armed,
    input wire logic soft_rst,
    input wire logic wr_rejected,
    input wire logic cmd_done,
    input wire logic [7:0] cmd_code
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // one completed frame carrying a given opcode
    sequence s_frame(logic [7:0] op);
        cmd_done && cmd_code == op;
    endsequence

    // address mode, reset pair, status write and bus release checks
    enter_wide_a: assert property (s_frame(OP_EN4B) |-> addr4)
        else $error("wide addressing not entered");
    wide_cause_a: assert property ($rose(addr4) |-> s_frame(OP_EN4B))
        else $error("wide addressing entered without its command");
    wide_exit_a: assert property ($fell(addr4) |-> soft_rst)
        else $error("wide addressing left without a reset");
    pair_fire_a: assert property (s_frame(OP_RST) |-> soft_rst == $past(rst_armed))
        else $error("reset command not gated by the enable");
    reset_effect_a: assert property (soft_rst |-> s_frame(OP_RST) ##0
        (!addr4 && !rst_armed && sr1[1:0] == 2'h0))
        else $error("soft reset left state behind");
    arm_set_a: assert property (s_frame(OP_RSTEN) |-> rst_armed)
        else $error("reset enable not armed");
    arm_drop_a: assert property (cmd_done && cmd_code != OP_RSTEN |-> !rst_armed)
        else $error("reset enable survived another frame");
    write_refuse_a: assert property (wr_rejected |->
        $stable(sr1) && cmd_code == OP_WRSR && !$past(sr1[1]))
        else $error("status write refusal wrong");
    latch_set_a: assert property ($rose(sr1[SR1_WEL]) |-> s_frame(OP_WREN))
        else $error("write enable set without its command");
    bus_free_a: assert property (cs_n [*3] |-> dev_dq_oe == 4'h0)
        else $error("device drives data while deselected");
endmodule

// ==== test/tb_address_mode_and_soft_reset_cmds.sv ====
// self-checking bench: host and device ends joined over the command link
module tb_address_mode_and_soft_reset_cmds import fa_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] lw = WID_1;
    logic req_valid = 1'b0;
    logic req_exit = 1'b0;
    logic [7:0] req_op = OP_IDLE;
    logic [23:0] req_addr = 24'h0;
    logic [7:0] req_wdata = 8'h0;
    logic [2:0] req_rd_len = 3'h0;
    logic req_ready, rsp_valid, addr4, rst_armed, soft_rst, wr_rejected, cmd_done;
    logic [31:0] rsp_data;
    logic [7:0] sr1, cmd_code, o, esr, d;
    logic [2:0] ws[3] = '{WID_1, WID_2, WID_4};
    logic [31:0] seed = 32'h8211;
    logic [31:0] got, rnd;
    logic saw_soft, saw_rej, en;
    logic [2:0] n;
    int n_mismatch = 0;
    int num_checks = 0;

    fa_link_if link();
    fa_dev fa_dev_i(.ref_clk(ref_clk), .nrst(nrst), .link(link), .link_width(lw),
        .addr4(addr4), .sr1(sr1), .rst_armed(rst_armed), .soft_rst(soft_rst),
        .wr_rejected(wr_rejected), .cmd_done(cmd_done), .cmd_code(cmd_code));
    fa_host fa_host_i(.ref_clk(ref_clk), .nrst(nrst), .link(link), .link_width(lw),
        .req_valid(req_valid), .req_exit(req_exit), .req_op(req_op), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_rd_len(req_rd_len), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    fa_asserts fa_asserts_i(.ref_clk(ref_clk), .nrst(nrst), .cs_n(link.cs_n),
        .dev_dq_oe(link.dev_dq_oe), .addr4(addr4), .sr1(sr1), .rst_armed(rst_armed),
        .soft_rst(soft_rst), .wr_rejected(wr_rejected), .cmd_done(cmd_done),
        .cmd_code(cmd_code));

    // 25 MHz clock
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // repeatable random source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // random link width
    function automatic logic [2:0] rw();
        logic [1:0] r;
        r = 2'(xs() % 32'h3);
        return ws[r];
    endfunction

    // expected parameter bytes, first byte ends highest
    function automatic logic [31:0] exp_rd(input logic [7:0] ofs, input logic [2:0] cnt);
        logic [31:0] r;
        logic [7:0] b;
        r = 32'h0;
        for (int i = 0; i < cnt; i++) begin
            case (8'(ofs + 8'(i)))
                8'h3C: b = 8'hF0;
                8'h3D: b = 8'h30;
                8'h3E: b = 8'hF8;
                8'h3F: b = 8'hA1;
                default: b = 8'hFF;
            endcase
            r = {r[23:0], b};
        end
        return r;
    endfunction

    // compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // one host request, waits out the frame and notes device events
    task automatic send(input logic ex, input logic [7:0] op, input logic [23:0] a,
                        input logic [7:0] wd, input logic [2:0] len, input logic [2:0] w);
        int k;
        k = 0;
        saw_soft = 1'b0;
        saw_rej = 1'b0;
        got = 32'h0;
        @(negedge ref_clk);
        while (req_ready !== 1'b1 && k < 2000) begin
            @(negedge ref_clk);
            k++;
        end
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_exit <= ex;
        req_op <= op;
        req_addr <= a;
        req_wdata <= wd;
        req_rd_len <= len;
        lw <= w;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        k = 0;
        while (req_ready === 1'b1 && k < 4) begin
            @(negedge ref_clk);
            k++;
        end
        k = 0;
        while (req_ready !== 1'b1 && k < 2000) begin
            @(negedge ref_clk);
            if (rsp_valid === 1'b1) got = rsp_data;
            if (soft_rst === 1'b1) saw_soft = 1'b1;
            if (wr_rejected === 1'b1) saw_rej = 1'b1;
            k++;
        end
        // a frame that never finishes counts against the run
        if (req_ready !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, req_ready, 1'b1);
        end
    endtask

    // plain command frame
    task automatic cmd(input logic [7:0] op, input logic [2:0] w);
        send(1'b0, op, 24'h0, 8'h0, 3'h0, w);
    endtask

    // verdict and end of run
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (40000) @(posedge ref_clk);
        n_mismatch++;
        end_sim();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        @(negedge ref_clk);
        chk(32'({addr4, sr1, cmd_code}), {15'h0, 1'b0, SR1_RESET, OP_IDLE});
        // wide mode and reset pair in every width
        for (int i = 0; i < 3; i++) begin
            cmd(OP_EN4B, ws[i]);
            chk(32'(addr4), 32'h1);
            cmd(OP_RSTEN, ws[i]);
            chk(32'(rst_armed), 32'h1);
            cmd(OP_RST, ws[i]);
            chk(32'({saw_soft, addr4}), 32'h2);
        end
        // reset without enable, then enable broken by another frame
        cmd(OP_EN4B, WID_1);
        cmd(OP_RST, WID_1);
        chk(32'({saw_soft, addr4}), 32'h1);
        for (int i = 0; i < 2; i++) begin
            cmd(OP_RSTEN, WID_2);
            send(i[0], i[0] ? OP_IDLE : OP_WREN, 24'h0, 8'h0, 3'h0, WID_2);
            chk(32'(rst_armed), 32'h0);
            cmd(OP_RST, WID_2);
            chk(32'({saw_soft, addr4}), 32'h1);
        end
        // mode exit first, then a valid pair
        send(1'b1, OP_IDLE, 24'h0, 8'h0, 3'h0, WID_4);
        cmd(OP_RSTEN, WID_4);
        cmd(OP_RST, WID_4);
        chk(32'({saw_soft, addr4}), 32'h2);
        // status writes with and without enable
        esr = {sr1[7:2], 2'h0};
        for (int i = 0; i < 8; i++) begin
            rnd = xs();
            d = rnd[7:0];
            rnd = xs();
            en = (i == 0) ? 1'b0 : rnd[0];
            if (en) cmd(OP_WREN, rw());
            if (en) chk(32'(sr1[SR1_WEL]), 32'h1);
            send(1'b0, OP_WRSR, 24'h0, d, 3'h0, rw());
            if (en) esr = {d[7:2], 2'h0};
            chk(32'({saw_rej, sr1}), 32'({!en, esr}));
        end
        // parameter area reads
        send(1'b0, OP_RDPAR, 24'h3C, 8'h0, 3'h4, WID_1);
        chk(got, 32'hF030F8A1);
        for (int i = 0; i < 8; i++) begin
            rnd = xs();
            o = 8'h38 + 8'(rnd[3:0]);
            n = 3'h1 + 3'(xs() % 32'h4);
            send(1'b0, OP_RDPAR, {16'h0, o}, 8'h0, n, rw());
            chk(n == 3'h4 ? got : got & ((32'h1 << (8 * n)) - 32'h1), exp_rd(o, n));
        end
        // hardware reset leaves wide mode
        cmd(OP_EN4B, WID_1);
        chk(32'(addr4), 32'h1);
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        @(negedge ref_clk);
        chk(32'(addr4), 32'h0);
        cmd(OP_RSTEN, WID_4);
        chk(32'(rst_armed), 32'h1);
        end_sim();
    end
endmodule
